// ===== logic/cil_defs.svh
`ifndef CIL_DEFS_SVH
`define CIL_DEFS_SVH

// Register byte offsets
`define CIL_OFF_CTRL 12'h000
`define CIL_OFF_EVENT 12'h004
`define CIL_OFF_STATUS 12'h008
`define CIL_OFF_ID 12'h00C

// Control register field positions
`define CIL_CTRL_PWR_OK 0
`define CIL_CTRL_OS_RUN 1
`define CIL_CTRL_OS_FAIL 2
`define CIL_CTRL_CSW_LOADING 3
`define CIL_CTRL_ROLE_LSB 4
`define CIL_CTRL_UPD_LSB 6
`define CIL_CTRL_KEY_LSB 8
`define CIL_CTRL_P0_LINK 11
`define CIL_CTRL_P0_TRAF 12
`define CIL_CTRL_P1_LINK 13
`define CIL_CTRL_P1_TRAF 14
`define CIL_CTRL_PARTNER 15
`define CIL_CTRL_RL_LINK 16
`define CIL_CTRL_RL_TRAF 17
`define CIL_CTRL_WIDTH 18

// Event register field positions (write one to fire)
`define CIL_EVT_CONN_OK 0
`define CIL_EVT_CONN_FAIL 1

// Reset values
`define CIL_CTRL_RESET 18'h00000

// Timing: flash half period and number of flashes per event
`define CIL_FLASH_HALF_MS 250
`define CIL_CLK_HZ 10000000
// Divide first so the product stays inside a 32-bit int
`define CIL_FLASH_HALF_CYC ((`CIL_CLK_HZ / 1000) * `CIL_FLASH_HALF_MS)
`define CIL_EVENT_FLASHES 3

`endif

// ===== logic/cil_pkg.sv
package cil_pkg;

    // Indicator colours, bit order {red, green, blue}
    typedef enum logic [2:0] {
        CIL_OFF_type_c = 3'h0,
        CIL_BLUE = 3'h1,
        CIL_GREEN = 3'h2,
        CIL_RED = 3'h4,
        CIL_ORANGE = 3'h6,
        CIL_PURPLE = 3'h5
    } cil_colour_type;

    // Redundancy role of the controller
    typedef enum logic [1:0] {
        CIL_ROLE_STANDALONE = 2'h0,
        CIL_ROLE_ACTIVE = 2'h1,
        CIL_ROLE_PASSIVE = 2'h2
    } cil_role_type;

    // Software update authentication result
    typedef enum logic [1:0] {
        CIL_UPD_NONE = 2'h0,
        CIL_UPD_AUTH_OK = 2'h1,
        CIL_UPD_AUTH_FAIL = 2'h2
    } cil_upd_type;

    // Key loading phase
    typedef enum logic [2:0] {
        CIL_KEY_IDLE = 3'h0,
        CIL_KEY_READY = 3'h1,
        CIL_KEY_NONE = 3'h2,
        CIL_KEY_VALIDATE = 3'h3,
        CIL_KEY_FAILED = 3'h4,
        CIL_KEY_LOADED = 3'h5
    } cil_key_type;

    // Connection event flasher states, Gray coded except the OFF to IDLE step
    typedef enum logic [1:0] {
        CIL_EV_IDLE = 2'b00,
        CIL_EV_ON = 2'b01,
        CIL_EV_OFF = 2'b11
    } cil_evst_type;

endpackage

// ===== logic/cil_indicator.sv
`timescale 1ns/100ps
`include "cil_defs.svh"

module cil_indicator
    import cil_pkg::*;
#(
    parameter int FLASH_HALF_CYC = `CIL_FLASH_HALF_CYC,
    parameter bit DUAL_PORT = 1'b1
)
(
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic [2:0] MODULE_STATE_INDICATOR,
    output logic [2:0] SECURITY_INDICATOR,
    output logic PORT0_YELLOW,
    output logic PORT1_YELLOW,
    output logic REDUNDANCY_LINK_INDICATOR
);

    // Elaboration check on the divider
    if (FLASH_HALF_CYC < 1 || FLASH_HALF_CYC > 32'h3FFFFFFF)
    begin : g_bad_half
        $error("FLASH_HALF_CYC out of range");
    end

    localparam logic [31:0] ID_VALUE = 32'h00C1_0001; // Arbitrary identification value

    logic [1:0] rst_sync; // Reset release synchroniser
    logic rst_n; // Synchronised reset
    logic [17:0] ctrl; // Software-written system state
    logic [31:0] div_cnt; // Flash divider counter
    logic phase; // Flash phase, equal on and off
    logic phase_tick; // Divider wrap pulse
    cil_evst_type ev_state; // Connection event flasher state
    logic [1:0] ev_count; // Flashes still to show after the current one
    logic ev_fail; // Current event is a failure
    logic ev_pend_ok; // Queued good event
    logic ev_pend_fail; // Queued failed event
    logic [2:0] next_status; // Next status colour
    logic [2:0] next_security; // Next security colour
    logic next_port0; // Next port 0 lamp
    logic next_port1; // Next port 1 lamp
    logic next_rlink; // Next redundancy lamp
    logic orange_seen; // Status has shown orange since power and OS last came up

    // Reset released through two flops
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    // Control field decode
    wire pwr_ok = ctrl[`CIL_CTRL_PWR_OK];
    wire os_run = ctrl[`CIL_CTRL_OS_RUN] & ~ctrl[`CIL_CTRL_OS_FAIL];
    wire csw_loading = ctrl[`CIL_CTRL_CSW_LOADING];
    wire [1:0] role = ctrl[`CIL_CTRL_ROLE_LSB +: 2];
    wire [1:0] upd = ctrl[`CIL_CTRL_UPD_LSB +: 2];
    wire [2:0] key = ctrl[`CIL_CTRL_KEY_LSB +: 3];

    // APB decode
    wire apb_access = PSEL & PENABLE;
    wire apb_wr = apb_access & PWRITE;
    wire hit_ctrl = (PADDR == `CIL_OFF_CTRL);
    wire hit_event = (PADDR == `CIL_OFF_EVENT);
    wire hit_status = (PADDR == `CIL_OFF_STATUS);
    wire hit_id = (PADDR == `CIL_OFF_ID);
    wire addr_ok = hit_ctrl | hit_event | hit_status | hit_id;
    wire evt_ok = apb_wr & hit_event & PWDATA[`CIL_EVT_CONN_OK];
    wire evt_fail = apb_wr & hit_event & PWDATA[`CIL_EVT_CONN_FAIL];
    wire [31:0] status_word = {16'h0000, orange_seen, ev_pend_fail, ev_pend_ok, ev_state != CIL_EV_IDLE,
        phase, REDUNDANCY_LINK_INDICATOR, PORT1_YELLOW, PORT0_YELLOW, 1'b0, SECURITY_INDICATOR,
        1'b0, MODULE_STATE_INDICATOR};
    wire [31:0] rd_mux = hit_ctrl ? {14'h0000, ctrl} : hit_status ? status_word :
        hit_id ? ID_VALUE : 32'h0000_0000;

    // APB slave: zero wait states, error on unmapped address
    always_ff @(posedge CORE_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl <= `CIL_CTRL_RESET;
            PRDATA <= 32'h0000_0000;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end
        else
        begin
            PREADY <= PSEL & ~PENABLE;
            PSLVERR <= PSEL & ~PENABLE & ~addr_ok;
            PRDATA <= rd_mux;
            if (apb_wr && hit_ctrl && PREADY)
                ctrl <= PWDATA[17:0];
        end
    end

    // Equal on/off flash divider
    assign phase_tick = (div_cnt == 32'(FLASH_HALF_CYC - 1));
    always_ff @(posedge CORE_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_cnt <= 32'h0000_0000;
            phase <= 1'b0;
        end
        else if (phase_tick)
        begin
            div_cnt <= 32'h0000_0000; // Wrap and toggle phase
            phase <= ~phase;
        end
        else
            div_cnt <= div_cnt + 32'h0000_0001;
    end

    // Three-flash connection event sequencer
    wire ev_start = (ev_state == CIL_EV_IDLE) & (ev_pend_ok | ev_pend_fail);
    // A queued event is handed over only on a divider wrap
    wire ev_go = ev_start & phase_tick;
    always_ff @(posedge CORE_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ev_state <= CIL_EV_IDLE;
            ev_count <= 2'h0;
            ev_fail <= 1'b0;
            ev_pend_ok <= 1'b0;
            ev_pend_fail <= 1'b0;
        end
        else
        begin
            // Pending flags clear only when a sequence starts; a new event wins over the clear
            ev_pend_ok <= evt_ok | (ev_pend_ok & ~(ev_go & ~ev_pend_fail));
            ev_pend_fail <= evt_fail | (ev_pend_fail & ~ev_go);
            case (ev_state)
                CIL_EV_IDLE:
                begin
                    if (ev_go)
                    begin
                        ev_state <= CIL_EV_ON;
                        ev_fail <= ev_pend_fail; // Failure reported first
                        ev_count <= 2'(`CIL_EVENT_FLASHES - 1);
                    end
                end
                CIL_EV_ON:
                begin
                    if (phase_tick)
                        ev_state <= CIL_EV_OFF;
                end
                CIL_EV_OFF:
                begin
                    if (phase_tick)
                    begin
                        if (ev_count == 2'h0)
                            ev_state <= CIL_EV_IDLE; // Sequence completes before steady colour
                        else
                        begin
                            ev_state <= CIL_EV_ON;
                            ev_count <= ev_count - 2'h1;
                        end
                    end
                end
                default:
                    ev_state <= CIL_EV_IDLE;
            endcase
        end
    end

    // Event flasher owns the security lamp while a sequence runs
    wire ev_busy = (ev_state != CIL_EV_IDLE);

    // Module status colour
    always_comb
    begin
        next_status = CIL_OFF_type_c;
        if (!pwr_ok)
            next_status = CIL_OFF_type_c;
        else if (upd == CIL_UPD_AUTH_FAIL)
            next_status = phase ? CIL_RED : CIL_OFF_type_c;
        else if (upd == CIL_UPD_AUTH_OK)
            next_status = phase ? CIL_GREEN : CIL_OFF_type_c;
        else if (!os_run)
            next_status = CIL_RED;
        else if (csw_loading)
            next_status = CIL_ORANGE;
        else if (role == CIL_ROLE_PASSIVE && DUAL_PORT)
            next_status = CIL_BLUE;
        else
            next_status = CIL_GREEN;
    end

    // Security colour
    always_comb
    begin
        next_security = CIL_OFF_type_c;
        if (!pwr_ok || !os_run)
            next_security = CIL_OFF_type_c;
        else if (ev_busy)
            next_security = (ev_state == CIL_EV_ON) ? (ev_fail ? CIL_ORANGE : CIL_GREEN)
                : CIL_OFF_type_c;
        else
        begin
            case (key)
                CIL_KEY_READY: next_security = CIL_PURPLE;
                CIL_KEY_NONE: next_security = phase ? CIL_PURPLE : CIL_OFF_type_c;
                CIL_KEY_VALIDATE: next_security = CIL_BLUE;
                CIL_KEY_FAILED: next_security = CIL_BLUE;
                CIL_KEY_LOADED: next_security = CIL_GREEN;
                default: next_security = CIL_RED;
            endcase
        end
    end

    // Network and redundancy lamps, traffic over solid
    always_comb
    begin
        next_port0 = pwr_ok & os_run & ctrl[`CIL_CTRL_P0_LINK] &
            (~ctrl[`CIL_CTRL_P0_TRAF] | phase);
        next_port1 = 1'b0;
        next_rlink = 1'b0;
        if (DUAL_PORT)
            next_rlink = pwr_ok & os_run & orange_seen & ctrl[`CIL_CTRL_PARTNER] &
                ctrl[`CIL_CTRL_RL_LINK] & (~ctrl[`CIL_CTRL_RL_TRAF] | phase);
    end

    // Registered lamp outputs
    always_ff @(posedge CORE_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            MODULE_STATE_INDICATOR <= 3'h0;
            SECURITY_INDICATOR <= 3'h0;
            PORT0_YELLOW <= 1'b0;
            PORT1_YELLOW <= 1'b0;
            REDUNDANCY_LINK_INDICATOR <= 1'b0;
            orange_seen <= 1'b0;
        end
        else
        begin
            MODULE_STATE_INDICATOR <= next_status;
            SECURITY_INDICATOR <= next_security;
            PORT0_YELLOW <= next_port0;
            PORT1_YELLOW <= next_port1;
            REDUNDANCY_LINK_INDICATOR <= next_rlink;
            // Latched once orange shows, dropped if power or OS go
            orange_seen <= (orange_seen | (next_status == CIL_ORANGE)) & pwr_ok & os_run;
        end
    end

    // Checks
    AST_RED_NO_OS: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        (pwr_ok && !os_run && upd == CIL_UPD_NONE) |=> MODULE_STATE_INDICATOR == CIL_RED)
        else $error("status not red without OS");
    AST_ORANGE: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        (pwr_ok && os_run && csw_loading && upd == CIL_UPD_NONE) |=> MODULE_STATE_INDICATOR == CIL_ORANGE)
        else $error("status not orange while loading");
    AST_SEC_DARK: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        !os_run |=> SECURITY_INDICATOR == CIL_OFF_type_c)
        else $error("security lit without OS");
    AST_KEY_FAIL_BLUE: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        (pwr_ok && os_run && !ev_busy && key == CIL_KEY_FAILED) |=> SECURITY_INDICATOR == CIL_BLUE)
        else $error("security not blue after key failure");
    AST_EV_START: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        (ev_start && phase_tick) |=> ev_state == CIL_EV_ON && ev_count == 2'h2)
        else $error("event flash did not start with three flashes");
    AST_EV_END: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        (ev_state == CIL_EV_OFF && ev_count == 2'h0 && phase_tick) |=> ev_state == CIL_EV_IDLE)
        else $error("event sequence did not finish");
    AST_PORT_DARK: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        (!os_run || !ctrl[`CIL_CTRL_P0_LINK]) |=> !PORT0_YELLOW)
        else $error("port lamp lit without link");
    AST_PORT_SOLID: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        (pwr_ok && os_run && ctrl[`CIL_CTRL_P0_LINK] && !ctrl[`CIL_CTRL_P0_TRAF]) |=> PORT0_YELLOW)
        else $error("port lamp not solid with idle link");
    AST_PORT1_UNUSED: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        !PORT1_YELLOW)
        else $error("second port lamp driven");
    AST_RLINK_GATE: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        !orange_seen |=> !REDUNDANCY_LINK_INDICATOR)
        else $error("redundancy lamp before orange");
    AST_DIV_HALF: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        $changed(phase) |-> $past(div_cnt) == 32'(FLASH_HALF_CYC - 1))
        else $error("flash phase changed off divider wrap");

    // Status colour checks
    AST_AUTH_FAIL_FLASH: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        (pwr_ok && upd == CIL_UPD_AUTH_FAIL)
        |=> MODULE_STATE_INDICATOR == ($past(phase) ? CIL_RED : CIL_OFF_type_c))
        else $error("status not flashing red on update failure");
    AST_AUTH_OK_FLASH: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        (pwr_ok && upd == CIL_UPD_AUTH_OK)
        |=> MODULE_STATE_INDICATOR == ($past(phase) ? CIL_GREEN : CIL_OFF_type_c))
        else $error("status not flashing green on update success");
    AST_ACTIVE_GREEN: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        (pwr_ok && os_run && !csw_loading && upd == CIL_UPD_NONE && (role != CIL_ROLE_PASSIVE || !DUAL_PORT))
        |=> MODULE_STATE_INDICATOR == CIL_GREEN)
        else $error("status not green when standalone or active");
    AST_PASSIVE_BLUE: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        (DUAL_PORT && pwr_ok && os_run && !csw_loading && upd == CIL_UPD_NONE && role == CIL_ROLE_PASSIVE)
        |=> MODULE_STATE_INDICATOR == CIL_BLUE)
        else $error("status not blue when passive");

    // Security colour checks
    AST_KEY_READY_PURPLE: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        (pwr_ok && os_run && !ev_busy && key == CIL_KEY_READY) |=> SECURITY_INDICATOR == CIL_PURPLE)
        else $error("security not purple when ready for keys");
    AST_KEY_NONE_FLASH: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        (pwr_ok && os_run && !ev_busy && key == CIL_KEY_NONE)
        |=> SECURITY_INDICATOR == ($past(phase) ? CIL_PURPLE : CIL_OFF_type_c))
        else $error("security not flashing purple without keys");
    AST_KEY_LOADED_GREEN: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        (pwr_ok && os_run && !ev_busy && key == CIL_KEY_LOADED) |=> SECURITY_INDICATOR == CIL_GREEN)
        else $error("security not green after keys loaded");
    AST_EV_OK_GREEN: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        (pwr_ok && os_run && ev_state == CIL_EV_ON && !ev_fail) |=> SECURITY_INDICATOR == CIL_GREEN)
        else $error("good connection flash not green");
    AST_EV_FAIL_ORANGE: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        (pwr_ok && os_run && ev_state == CIL_EV_ON && ev_fail) |=> SECURITY_INDICATOR == CIL_ORANGE)
        else $error("failed connection flash not orange");
    AST_EV_FAIL_FIRST: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        (ev_go && ev_pend_fail) |=> ev_fail)
        else $error("queued failure not shown first");
    AST_EV_PEND_SET: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        evt_ok |=> ev_pend_ok)
        else $error("good connection event not queued");

    // Port and redundancy lamp checks
    AST_PORT_BLINK: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        (pwr_ok && os_run && ctrl[`CIL_CTRL_P0_LINK] && ctrl[`CIL_CTRL_P0_TRAF]) |=> PORT0_YELLOW == $past(phase))
        else $error("port lamp not blinking with traffic");
    AST_RLINK_DARK: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        (!os_run || !ctrl[`CIL_CTRL_PARTNER]) |=> !REDUNDANCY_LINK_INDICATOR)
        else $error("redundancy lamp lit without partner or OS");
    AST_RLINK_SOLID: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        (DUAL_PORT && pwr_ok && os_run && orange_seen && ctrl[`CIL_CTRL_PARTNER] && ctrl[`CIL_CTRL_RL_LINK]
        && !ctrl[`CIL_CTRL_RL_TRAF]) |=> REDUNDANCY_LINK_INDICATOR)
        else $error("redundancy lamp not solid with good link");
    AST_RLINK_BLINK: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        (DUAL_PORT && pwr_ok && os_run && orange_seen && ctrl[`CIL_CTRL_PARTNER] && ctrl[`CIL_CTRL_RL_LINK]
        && ctrl[`CIL_CTRL_RL_TRAF]) |=> REDUNDANCY_LINK_INDICATOR == $past(phase))
        else $error("redundancy lamp not blinking with pair traffic");
    AST_SINGLE_NO_RLINK: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        !DUAL_PORT |-> !REDUNDANCY_LINK_INDICATOR)
        else $error("single-port variant lit redundancy lamp");

endmodule

// ===== sim/cil_lamp_watch.sv
`timescale 1ns/100ps
// Viewer model: counts how often a lamp enters each colour code
module cil_lamp_watch
(
    input wire logic clk,
    input wire logic clr,
    input wire logic [2:0] colour,
    output logic [7:0] enters [0:7]
);
    logic [2:0] last; // Colour seen at the previous edge
    // Count each change into a colour, clear on request
    always @(posedge clk)
    begin
        last <= colour;
        for (int i = 0; i < 8; i++)
        begin
            if (clr)
            begin
                enters[i] <= 8'h00;
            end
            else if (colour != last && colour == i[2:0])
            begin
                enters[i] <= enters[i] + 8'h01;
            end
        end
    end
endmodule

// ===== sim/cil_indicator_tb_top.sv
`timescale 1ns/100ps
`include "cil_defs.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fails++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end

module cil_indicator_tb_top
    import cil_pkg::*;
;
    localparam int HALF = 4; // Short flash half period
    localparam int WIN = 48; // Flash observation window
    localparam logic [31:0] PWR = 32'h1 << `CIL_CTRL_PWR_OK;
    localparam logic [31:0] OS = 32'h1 << `CIL_CTRL_OS_RUN;
    localparam logic [31:0] OSF = 32'h1 << `CIL_CTRL_OS_FAIL;
    localparam logic [31:0] CSW = 32'h1 << `CIL_CTRL_CSW_LOADING;
    localparam logic [31:0] P0L = 32'h1 << `CIL_CTRL_P0_LINK;
    localparam logic [31:0] P0T = 32'h1 << `CIL_CTRL_P0_TRAF;
    localparam logic [31:0] PRT = 32'h1 << `CIL_CTRL_PARTNER;
    localparam logic [31:0] RLL = 32'h1 << `CIL_CTRL_RL_LINK;
    localparam logic [31:0] RLT = 32'h1 << `CIL_CTRL_RL_TRAF;
    logic CORE_CLK = 1'b0;
    logic NRST = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] st_lamp;
    logic [2:0] sec_lamp;
    logic p0;
    logic p1;
    logic rl;
    logic rl_single; // Redundancy lamp of the single-port variant
    logic clr = 1'b1;
    logic [7:0] ent [0:3][0:7]; // Colour entries per watched lamp
    int fails = 0;
    int compares = 0;
    logic [31:0] rd;
    logic err;
    logic [31:0] cw;
    logic [2:0] key;
    logic [31:0] ftab [0:4]; // Control words that make a lamp flash
    int fsel [0:4] = '{0, 0, 1, 2, 3};
    int fcol [0:4] = '{4, 2, 5, 1, 1};
    logic [2:0] keys [0:4] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5};

    // Clock of 100 ns period
    always #50 CORE_CLK = ~CORE_CLK;

    cil_indicator #(.FLASH_HALF_CYC(HALF), .DUAL_PORT(1'b1)) u_dut (.CORE_CLK(CORE_CLK), .NRST(NRST),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .MODULE_STATE_INDICATOR(st_lamp), .SECURITY_INDICATOR(sec_lamp),
        .PORT0_YELLOW(p0), .PORT1_YELLOW(p1), .REDUNDANCY_LINK_INDICATOR(rl));
    // Single-port variant shares the bus and only its redundancy lamp is watched
    cil_indicator #(.FLASH_HALF_CYC(HALF), .DUAL_PORT(1'b0)) u_dut_single (.CORE_CLK(CORE_CLK), .NRST(NRST),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(),
        .PREADY(), .PSLVERR(), .MODULE_STATE_INDICATOR(), .SECURITY_INDICATOR(),
        .PORT0_YELLOW(), .PORT1_YELLOW(), .REDUNDANCY_LINK_INDICATOR(rl_single));
    cil_lamp_watch u_w0 (.clk(CORE_CLK), .clr(clr), .colour(st_lamp), .enters(ent[0]));
    cil_lamp_watch u_w1 (.clk(CORE_CLK), .clr(clr), .colour(sec_lamp), .enters(ent[1]));
    cil_lamp_watch u_w2 (.clk(CORE_CLK), .clr(clr), .colour({2'b00, p0}), .enters(ent[2]));
    cil_lamp_watch u_w3 (.clk(CORE_CLK), .clr(clr), .colour({2'b00, rl}), .enters(ent[3]));

    // Waits a number of clock edges
    task automatic tick(input int n);
        repeat (n) @(posedge CORE_CLK);
    endtask

    // One APB transfer: setup, access until pready, then release
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge CORE_CLK);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge CORE_CLK);
        penable <= 1'b1;
        do
        begin
            @(posedge CORE_CLK);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            fails++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Writes the control word and lets the lamps settle
    task automatic ctrl(input logic [31:0] d);
        apb(1'b1, `CIL_OFF_CTRL, d);
        tick(3);
    endtask

    // Restarts the viewer counts
    task automatic restart();
        clr <= 1'b1;
        tick(1);
        clr <= 1'b0;
    endtask

    // Security colour expected for a steady key phase
    function automatic logic [2:0] sec_exp(input logic [2:0] k);
        case (k)
            3'h0: return CIL_RED;
            3'h1: return CIL_PURPLE;
            3'h3, 3'h4: return CIL_BLUE;
            3'h5: return CIL_GREEN;
            default: return CIL_OFF_type_c;
        endcase
    endfunction

    // True when a count of flashes fits the observation window
    function automatic logic flash_ok(input logic [7:0] c);
        return (c >= WIN / (2 * HALF) - 1) && (c <= WIN / (2 * HALF) + 1);
    endfunction

    // Prints the counts and the verdict
    task automatic end_sim();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Watchdog against a hang
    initial
    begin
        #(100 * 20000);
        fails++;
        end_sim();
    end

    // Main sequence
    initial
    begin
        rd = $urandom(33);
        tick(6);
        NRST <= 1'b1;
        tick(4);
        `CHK("status after reset", CIL_OFF_type_c, st_lamp);
        ctrl(PWR | P0L | PRT | RLL);
        `CHK("status no os", CIL_RED, st_lamp); // Powered, no OS
        `CHK("security start", CIL_OFF_type_c, sec_lamp); // Dark at start
        `CHK("port no os", 1'b0, p0); // Dark without OS
        ctrl(PWR | OS | P0L | PRT | RLL);
        `CHK("status standalone", CIL_GREEN, st_lamp); // Standalone
        `CHK("security os", CIL_RED, sec_lamp); // OS running
        `CHK("port link", 1'b1, p0); // Link idle
        `CHK("rlink before orange", 1'b0, rl); // Not before orange
        ctrl(PWR | OS | CSW | PRT | RLL);
        `CHK("status loading", CIL_ORANGE, st_lamp); // Loading
        ctrl(PWR | OS | (32'h2 << `CIL_CTRL_ROLE_LSB) | PRT | RLL);
        `CHK("status passive", CIL_BLUE, st_lamp); // Passive member
        `CHK("rlink linked", 1'b1, rl); // Partner linked
        `CHK("rlink single", 1'b0, rl_single); // Single variant
        $display("test boot done");
        apb(1'b1, `CIL_OFF_CTRL, 32'hFFFF_FFFB);
        apb(1'b0, `CIL_OFF_CTRL, 32'h0);
        `CHK("ctrl readback", 32'h0003_FFFB, rd);
        apb(1'b1, 12'h010, 32'hFFFF_FFFF);
        `CHK("unmapped write err", 1'b1, err);
        apb(1'b0, 12'h010, 32'h0);
        `CHK("unmapped read err", 1'b1, err);
        `CHK("unmapped read data", 32'h0, rd);
        apb(1'b0, `CIL_OFF_EVENT, 32'h0);
        `CHK("event read", 32'h0, rd);
        $display("test bus done");
        for (int i = 0; i < 12; i++)
        begin
            key = keys[$urandom % 5];
            cw = PWR | OS | (($urandom % 3) << `CIL_CTRL_ROLE_LSB) | (32'(key) << `CIL_CTRL_KEY_LSB);
            cw = cw | ($urandom & (P0L | PRT | RLL | (32'h1 << `CIL_CTRL_P1_LINK)));
            ctrl(cw);
            `CHK("status role", (cw[5:4] == 2'h2) ? CIL_BLUE : CIL_GREEN, st_lamp); // Role
            `CHK("security key", sec_exp(key), sec_lamp); // Key phase
            `CHK("port0", cw[`CIL_CTRL_P0_LINK], p0); // Link
            `CHK("port1", 1'b0, p1); // Unused port
            `CHK("rlink", cw[`CIL_CTRL_PARTNER] & cw[`CIL_CTRL_RL_LINK], rl); // Partner
            `CHK("rlink single", 1'b0, rl_single); // Single variant
        end
        $display("test random done");
        ftab = '{PWR | OS | (32'h2 << `CIL_CTRL_UPD_LSB), PWR | OS | (32'h1 << `CIL_CTRL_UPD_LSB),
            PWR | OS | (32'h2 << `CIL_CTRL_KEY_LSB), PWR | OS | P0L | P0T, PWR | OS | PRT | RLL | RLT};
        for (int i = 0; i < 5; i++)
        begin
            ctrl(ftab[i]);
            restart();
            tick(WIN);
            `CHK("flash on", 1'b1, flash_ok(ent[fsel[i]][fcol[i]])); // Lit
            `CHK("flash off", 1'b1, flash_ok(ent[fsel[i]][0])); // Dark
        end
        $display("test flash done");
        ctrl(PWR | OS | (32'h5 << `CIL_CTRL_KEY_LSB));
        for (int i = 0; i < 3; i++)
        begin
            restart();
            apb(1'b1, `CIL_OFF_EVENT, (i == 2) ? 32'h3 : 32'h1 << i);
            tick(80);
            `CHK("event dark", (i == 2) ? 8'h06 : 8'h03, ent[1][0]); // One gap per flash
            `CHK("event orange", (i == 0) ? 8'h00 : 8'h03, ent[1][6]); // Three orange on failure
            `CHK("event end", CIL_GREEN, sec_lamp); // Back to green
        end
        $display("test events done");
        ctrl(PWR | OS | OSF | PRT | RLL);
        `CHK("status failed", CIL_RED, st_lamp); // OS failed
        $display("test fail done");
        end_sim();
    end
endmodule
